// ### rtl/serial_clock_divider.sv
// Prescaler and half-period divider feeding the serial clock sequencer
`timescale 1ns/1ps
module serial_clock_divider
    import spi_rx_pkg::*;
#(
    parameter int PS_W  = 15,
    parameter int DIV_W = 7
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Control
    input  wire logic                  restart,
    input  wire logic [PS_FIELD_W-1:0] ps_sel,
    input  wire logic [DIV_W-1:0]      div_val,
    // Half-period strobe
    output logic                       half_tick
);

    generate
        if (PS_W < 1 || PS_W >= (1 << PS_FIELD_W) || DIV_W < 1) begin : g_chk
            $error("serial_clock_divider: unsupported widths");
        end
    endgenerate

    logic [PS_W-1:0]  psc_cnt_reg;
    logic [PS_W-1:0]  ps_mask;
    logic             mck_tick;
    logic [DIV_W-1:0] div_cnt_reg;
    logic [DIV_W-1:0] half_len;

    // Channel operation clock is one tick every 2^ps_sel system clocks
    always_comb begin
        ps_mask  = PS_W'((1 << ps_sel) - 1);
        mck_tick = &(psc_cnt_reg | ~ps_mask);
    end

    // Never below the fastest allowed half period
    always_comb begin
        if (int'(div_val) < MIN_HALF_CYCLES - 1) begin
            half_len = DIV_W'(MIN_HALF_CYCLES - 1);
        end else begin
            half_len = div_val;
        end
    end

    // Free running, so the first half after a restart may be short
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            psc_cnt_reg <= '0;
        end else begin
            psc_cnt_reg <= psc_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt_reg <= '0;
            half_tick   <= 1'b0;
        end else if (restart) begin
            div_cnt_reg <= '0;
            half_tick   <= 1'b0;
        end else if (mck_tick && div_cnt_reg == half_len) begin
            div_cnt_reg <= '0;
            half_tick   <= 1'b1;
        end else begin
            div_cnt_reg <= div_cnt_reg + DIV_W'(mck_tick);
            half_tick   <= 1'b0;
        end
    end

endmodule : serial_clock_divider

// ### rtl/spi_master_receive_channel.sv
// Clocked serial master receive channel with Wishbone register slave
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps

// Overview of operation
// - Channel drives the serial clock and samples the serial input.
// - Interrupt source: 0 transfer end (single), 1 buffer full (continuous).
// - Overrun is the only error, shown in its own flag.
// - Received word is 7 or 8 bits.
// - Serial clock from system_clock_freq/4 down to system_clock_freq/(2*2^15*128).
// - Phase 0: input starts with the first serial clock edge; each bit is sampled as its second half ends.
// - Phase 1: input starts half a clock before the serial clock.
// - Polarity bit 0 normal, 1 inverted serial clock.
// - Words assembled MSB first or LSB first.
// - Operation clock from prescaler output zero or one.
// - No data output is driven; output enable plays no part.
// - Received data sits in the low 8 bits of the data register.
// - Interrupt source may change while receiving, before the last bit.
module spi_master_receive_channel
    import spi_rx_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int PS_W   = 15,
    parameter int DIV_W  = 7
) (
    // System
    input  wire logic              CLK,
    input  wire logic              RST,
    // Wishbone slave
    input  wire logic              WB_CYC_I,
    input  wire logic              WB_STB_I,
    input  wire logic              WB_WE_I,
    input  wire logic [ADDR_W-1:0] WB_ADR_I,
    input  wire logic [3:0]        WB_SEL_I,
    input  wire logic [31:0]       WB_DAT_I,
    output logic      [31:0]       WB_DAT_O,
    output logic                   WB_ACK_O,
    // Serial link
    output logic                   SERIAL_CLOCK_PIN,
    input  wire logic              SERIAL_IN_PIN,
    // Interrupt
    output logic                   IRQ
);

    generate
        if (ADDR_W < 8 || DIV_W != 7 || PS_W != 15) begin : g_chk
            $error("spi_master_receive_channel: unsupported parameters");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    mode_cfg_type         mode_reg;
    comm_cfg_type         comm_reg;
    logic [7:0]           ps_reg;
    logic [DIV_W-1:0]     div_reg;
    logic                 run_reg;
    logic                 pend_reg;
    logic [7:0]           rx_buf_reg;
    logic                 full_reg;
    logic [IRQ_W-1:0]     ist_reg;
    logic [IRQ_W-1:0]     mask_reg;
    logic [7:0]           shift_reg;
    logic [7:0]           shift_next;
    logic [2:0]           bit_cnt_reg;
    rx_state_type         state_reg;
    rx_state_type         state_next;
    logic [2:0]           sync_reg;
    logic                 si_reg;
    logic                 half_tick;
    logic                 bus_req;
    logic                 wr_en;
    logic                 rd_en;
    logic                 sample;
    logic                 word_done;
    logic                 last_bit;
    logic                 go;
    logic [PS_FIELD_W-1:0] ps_sel;
    logic [7:0]           word_out;
    logic [31:0]          rd_data;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // One wait state: request taken on the edge that raises the ack
    always_comb begin
        bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
        wr_en   = bus_req && WB_WE_I && WB_SEL_I[0];
        rd_en   = bus_req && !WB_WE_I;
    end

    function automatic logic hit(input logic [ADDR_W-1:0] adr,
                                 input logic [7:0] ofs);
        hit = (adr == ADDR_W'(ofs));
    endfunction : hit

    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit(WB_ADR_I, OFS_MODE)) begin
            rd_data[MODE_W-1:0] = mode_reg;
        end else if (hit(WB_ADR_I, OFS_COMM)) begin
            rd_data[COMM_W-1:0] = comm_reg;
        end else if (hit(WB_ADR_I, OFS_DATA)) begin
            rd_data[7:0] = rx_buf_reg;
        end else if (hit(WB_ADR_I, OFS_START)) begin
            rd_data[START_CH_BIT] = run_reg;
        end else if (hit(WB_ADR_I, OFS_STATUS)) begin
            rd_data[ST_BUSY_BIT] = (state_reg != ST_IDLE);
            rd_data[ST_FULL_BIT] = full_reg;
        end else if (hit(WB_ADR_I, OFS_IRQ_ST)) begin
            rd_data[IRQ_W-1:0] = ist_reg;
        end else if (hit(WB_ADR_I, OFS_IRQ_MASK)) begin
            rd_data[IRQ_W-1:0] = mask_reg;
        end else if (hit(WB_ADR_I, OFS_PRESCALE)) begin
            rd_data[7:0] = ps_reg;
        end else if (hit(WB_ADR_I, OFS_DIVIDE)) begin
            rd_data[DIV_W-1:0] = div_reg;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= bus_req;
            if (rd_en) begin
                WB_DAT_O <= rd_data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // Mode may be rewritten mid-word; the interrupt source is read at each word end, the clock select at once
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mode_reg <= '0;
            comm_reg <= '0;
            ps_reg   <= PS_RESET;
            div_reg  <= DIV_RESET;
            mask_reg <= '0;
        end else if (wr_en) begin
            if (hit(WB_ADR_I, OFS_MODE)) begin
                mode_reg <= mode_cfg_type'(WB_DAT_I[MODE_W-1:0]);
            end else if (hit(WB_ADR_I, OFS_COMM)) begin
                comm_reg <= comm_cfg_type'(WB_DAT_I[COMM_W-1:0]);
            end else if (hit(WB_ADR_I, OFS_PRESCALE)) begin
                ps_reg <= WB_DAT_I[7:0];
            end else if (hit(WB_ADR_I, OFS_DIVIDE)) begin
                div_reg <= WB_DAT_I[DIV_W-1:0];
            end else if (hit(WB_ADR_I, OFS_IRQ_MASK)) begin
                mask_reg <= WB_DAT_I[IRQ_W-1:0];
            end
        end
    end

    // Only this channel's start bit matters; other bits are ignored
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            run_reg <= 1'b0;
        end else if (wr_en && hit(WB_ADR_I, OFS_START)
                     && WB_DAT_I[START_CH_BIT]) begin
            run_reg <= 1'b1;
        end else if (wr_en && hit(WB_ADR_I, OFS_STOP)
                     && WB_DAT_I[START_CH_BIT]) begin
            run_reg <= 1'b0;
        end
    end

    // A dummy write to the data register requests one word in single mode
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pend_reg <= 1'b0;
        end else if (!run_reg) begin
            pend_reg <= 1'b0;
        end else if (wr_en && hit(WB_ADR_I, OFS_DATA)) begin
            pend_reg <= 1'b1;
        end else if (go && state_reg == ST_IDLE) begin
            pend_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Serial input synchroniser
    // ------------------------------------------------------------------
    // A level counts only once the second and third stages agree
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sync_reg <= 3'h0;
            si_reg   <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[1:0], SERIAL_IN_PIN};
            if (sync_reg[1] == sync_reg[2]) begin
                si_reg <= sync_reg[2];
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial clock timing
    // ------------------------------------------------------------------
    assign ps_sel = mode_reg.ck_sel ? ps_reg[7:4] : ps_reg[3:0];

    // Divider restarts while idle; the prescaler runs free, so a frame's first half may be short
    serial_clock_divider #(
        .PS_W  (PS_W),
        .DIV_W (DIV_W)
    ) u_div (
        .clk       (CLK),
        .rst       (RST),
        .restart   (state_reg == ST_IDLE),
        .ps_sel    (ps_sel),
        .div_val   (div_reg),
        .half_tick (half_tick)
    );

    // ------------------------------------------------------------------
    // Receive sequencer
    // ------------------------------------------------------------------
    always_comb begin
        go       = run_reg && (mode_reg.irq_src || pend_reg);
        last_bit = (bit_cnt_reg == (comm_reg.len7 ? 3'h6 : 3'h7));
        // Phase 1 samples on the trailing edge, phase 0 on the leading one
        sample   = half_tick
                   && ((state_reg == ST_FIRST && comm_reg.data_phase)
                       || (state_reg == ST_SECOND
                           && !comm_reg.data_phase));
        word_done = half_tick && state_reg == ST_SECOND && last_bit;
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (go) begin
                    state_next = comm_reg.data_phase ? ST_LEAD
                                                     : ST_FIRST;
                end
            end
            ST_LEAD: begin
                if (half_tick) begin
                    state_next = ST_FIRST;
                end
            end
            ST_FIRST: begin
                if (half_tick) begin
                    state_next = ST_SECOND;
                end
            end
            ST_SECOND: begin
                if (half_tick && !last_bit) begin
                    state_next = ST_FIRST;
                end else if (word_done && run_reg && mode_reg.irq_src) begin
                    state_next = ST_FIRST;
                end else if (word_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Stopping aborts the word in progress
        if (!run_reg) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Clock is at its active level during the first half of each bit
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            SERIAL_CLOCK_PIN <= 1'b1;
        end else begin
            SERIAL_CLOCK_PIN <= (state_next == ST_FIRST)
                                ? comm_reg.clk_pol
                                : !comm_reg.clk_pol;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bit_cnt_reg <= 3'h0;
        end else if (state_reg == ST_IDLE || word_done) begin
            bit_cnt_reg <= 3'h0;
        end else if (half_tick && state_reg == ST_SECOND) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Word assembly
    // ------------------------------------------------------------------
    always_comb begin
        if (comm_reg.lsb_first) begin
            shift_next = {si_reg, shift_reg[7:1]};
        end else begin
            shift_next = {shift_reg[6:0], si_reg};
        end
        // LSB-first seven-bit words sit one place high until aligned
        if (comm_reg.lsb_first && comm_reg.len7) begin
            word_out = {1'b0, shift_reg[7:1]};
        end else if (comm_reg.len7) begin
            word_out = {1'b0, shift_reg[6:0]};
        end else begin
            word_out = shift_reg;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            shift_reg <= 8'h00;
        end else if (sample) begin
            shift_reg <= shift_next;
        end
    end

    // ------------------------------------------------------------------
    // Receive buffer and events
    // ------------------------------------------------------------------
    // Word is moved one cycle after its last half, when shift_reg holds it
    logic move_reg;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            move_reg <= 1'b0;
        end else begin
            move_reg <= word_done;
        end
    end

    // A new word wins over a read in the same cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rx_buf_reg <= 8'h00;
            full_reg   <= 1'b0;
        end else if (move_reg) begin
            rx_buf_reg <= word_out;
            full_reg   <= 1'b1;
        end else if (rd_en && hit(WB_ADR_I, OFS_DATA)) begin
            full_reg <= 1'b0;
        end
    end

    // Sticky status, write one to clear; a same-cycle event wins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ist_reg <= '0;
        end else begin
            for (int i = 0; i < IRQ_W; i++) begin
                if (wr_en && hit(WB_ADR_I, OFS_IRQ_ST) && WB_DAT_I[i]) begin
                    ist_reg[i] <= 1'b0;
                end
            end
            if (move_reg) begin
                ist_reg[IRQ_WORD_BIT] <= 1'b1;
            end
            if (move_reg && full_reg) begin
                ist_reg[IRQ_OVR_BIT] <= 1'b1;
            end
        end
    end

    // No data output exists; only clock and input pins serve the link
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(ist_reg & mask_reg);
        end
    end

endmodule : spi_master_receive_channel

// ### rtl/spi_rx_pkg.sv
// Constants and types shared by the clocked serial master receive channel
package spi_rx_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int SYS_CLK_PERIOD_NS = 10;
    localparam int SCK_MIN_PERIOD_NS = 40;
    // Shortest serial clock half period in system clocks, rounded up
    localparam int MIN_HALF_CYCLES =
        (SCK_MIN_PERIOD_NS + 2 * SYS_CLK_PERIOD_NS - 1)
        / (2 * SYS_CLK_PERIOD_NS);

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_MODE     = 8'h00;
    localparam logic [7:0] OFS_COMM     = 8'h04;
    localparam logic [7:0] OFS_DATA     = 8'h08;
    localparam logic [7:0] OFS_START    = 8'h0C;
    localparam logic [7:0] OFS_STOP     = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;
    localparam logic [7:0] OFS_IRQ_ST   = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
    localparam logic [7:0] OFS_PRESCALE = 8'h20;
    localparam logic [7:0] OFS_DIVIDE   = 8'h24;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int START_CH_BIT  = 0;
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_FULL_BIT   = 1;
    localparam int IRQ_WORD_BIT  = 0;
    localparam int IRQ_OVR_BIT   = 1;
    localparam int PS_FIELD_W    = 4;
    localparam int MODE_W        = 2;
    localparam int COMM_W        = 4;
    localparam int IRQ_W         = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PS_RESET  = 8'h00;
    localparam logic [6:0] DIV_RESET = 7'h01;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Bit 1 operation clock select, bit 0 interrupt source select
    typedef struct packed {
        logic ck_sel;
        logic irq_src;
    } mode_cfg_type;

    // Bit 3 seven-bit word, bit 2 LSB first, bit 1 polarity, bit 0 phase
    typedef struct packed {
        logic len7;
        logic lsb_first;
        logic clk_pol;
        logic data_phase;
    } comm_cfg_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LEAD,
        ST_FIRST,
        ST_SECOND
    } rx_state_type;

endpackage : spi_rx_pkg

// ### test/spi_master_receive_channel_test.sv
// Self-checking bench for the serial master receive channel
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module spi_master_receive_channel_test;
    import spi_rx_pkg::*;
    logic        clk, rst, cyc, stb, we, ack, sck, sdi, irq;
    logic        load, phase, pol;
    logic [7:0]  adr;
    logic [31:0] wdat, q, dat_o;
    logic [15:0] stream;
    logic [3:0]  cfg [7] = '{4'h0, 4'h3, 4'h4, 4'h8, 4'hC, 4'h1, 4'h2};
    int          n_mismatch, num_checks, c, i;

    spi_master_receive_channel spi_master_receive_channel_inst (.CLK(clk),
        .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .SERIAL_CLOCK_PIN(sck), .SERIAL_IN_PIN(sdi),
        .IRQ(irq));
    spi_slave_model spi_slave_model_inst (.sck(sck), .sdi(sdi), .load(load),
        .stream(stream), .phase(phase), .pol(pol));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    task timeout;
        n_mismatch++;
        end_of_test();
    endtask : timeout

    // One classic cycle; the request stands until ack is seen
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk);
        if (n == 20) timeout();
        q = dat_o;
        {cyc, stb} <= 2'b00;
    endtask : wb

    task rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask : rd

    task wait_irq;
        int n;
        for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk);
        if (irq !== 1'b1) timeout();
    endtask : wait_irq

    // Skip the first half, which may be short, and time the next one
    task half(output int cnt);
        int n, e;
        logic l;
        l = sck;
        e = 0;
        cnt = 0;
        for (n = 0; n < 500 && e < 3; n++) begin
            @(posedge clk);
            if (e == 2) cnt++;
            if (sck !== l) begin
                e++;
                l = sck;
            end
        end
        if (e < 3) timeout();
    endtask : half

    function automatic logic [7:0] exp_word(logic [3:0] cf, logic [15:0] s);
        logic [7:0] w;
        int n;
        w = 8'h00;
        n = cf[3] ? 7 : 8;
        for (int k = 0; k < n; k++)
            if (cf[2]) w[k] = s[15-k];
            else w[n-1-k] = s[15-k];
        return w;
    endfunction : exp_word

    task setup(input logic [3:0] cf);
        wb(1'b1, OFS_COMM, {28'h0, cf});
        {phase, pol, stream, load} <= {cf[0], cf[1], 16'hB26E, 1'b1};
        @(posedge clk);
        load <= 1'b0;
    endtask : setup

    task rate(input logic [7:0] ps, input logic [1:0] md, input int e);
        wb(1'b1, OFS_PRESCALE, {24'h0, ps});
        wb(1'b1, OFS_MODE, {30'h0, md});
        wb(1'b1, OFS_DATA, 32'h0);
        half(c);
        `CHK(c, e)
        wait_irq();
        wb(1'b1, OFS_IRQ_ST, 32'h3);
        wb(1'b0, OFS_DATA, 32'h0);
    endtask : rate

    initial begin
        {cyc, stb, we, adr, wdat, load, phase, pol, stream} = '0;
        {n_mismatch, num_checks} = '0;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK({sck, irq}, 2'b10)
        rd(OFS_IRQ_MASK, 32'h0);
        rd(OFS_DIVIDE, {25'h0, DIV_RESET});
        rd(OFS_PRESCALE, {24'h0, PS_RESET});
        wb(1'b1, 8'hFC, 32'hFF);
        rd(8'hFC, 32'h0);
        $display("reset test done");
        wb(1'b1, OFS_START, 32'h1);
        wb(1'b1, OFS_IRQ_MASK, 32'h1);
        rate(8'h10, 2'b10, 4);
        rate(8'h10, 2'b00, 2);
        $display("rate test done");
        wb(1'b1, OFS_DIVIDE, 32'h7);
        for (i = 0; i < 7; i++) begin
            setup(cfg[i]);
            wb(1'b1, OFS_DATA, 32'h0);
            wait_irq();
            rd(OFS_DATA, exp_word(cfg[i], 16'hB26E));
            wb(1'b1, OFS_IRQ_ST, 32'h3);
            rd(OFS_STATUS, 32'h0);
        end
        $display("format test done");
        setup(4'h0);
        wb(1'b1, OFS_MODE, 32'h1);
        for (i = 0; i < 200; i++) begin
            wb(1'b0, OFS_IRQ_ST, 32'h0);
            if (q[1] === 1'b1) break;
        end
        wb(1'b1, OFS_STOP, 32'h1);
        rd(OFS_IRQ_ST, 32'h3);
        rd(OFS_DATA, exp_word(4'h0, 16'h6E00));
        wb(1'b1, OFS_IRQ_MASK, 32'h0);
        @(negedge clk);
        `CHK(irq, 1'b0)
        wb(1'b1, OFS_IRQ_MASK, 32'h2);
        @(negedge clk);
        `CHK(irq, 1'b1)
        wb(1'b1, OFS_IRQ_ST, 32'h3);
        @(negedge clk);
        `CHK(irq, 1'b0)
        wb(1'b1, OFS_IRQ_MASK, 32'h1);
        $display("continuous test done");
        setup(4'h0);
        wb(1'b1, OFS_START, 32'h1);
        wb(1'b1, OFS_MODE, 32'h0);
        wait_irq();
        wb(1'b1, OFS_IRQ_ST, 32'h3);
        repeat (400) @(posedge clk);
        rd(OFS_IRQ_ST, 32'h0);
        rd(OFS_STATUS, 32'h2);
        $display("source switch test done");
        wb(1'b1, OFS_DATA, 32'h0);
        rd(OFS_STATUS, 32'h3);
        repeat (20) @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        `CHK({sck, irq}, 2'b10)
        rd(OFS_STATUS, 32'h0);
        rd(OFS_START, 32'h0);
        rd(OFS_DIVIDE, {25'h0, DIV_RESET});
        $display("mid-run reset test done");
        end_of_test();
    end
endmodule : spi_master_receive_channel_test

// ### test/spi_rx_asserts.sv
// Port-level checker for the serial receive channel
`timescale 1ns/1ps
module spi_rx_asserts
    import spi_rx_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // System
    input wire logic              CLK,
    input wire logic              RST,
    // Wishbone
    input wire logic              WB_CYC_I,
    input wire logic              WB_STB_I,
    input wire logic              WB_WE_I,
    input wire logic [ADDR_W-1:0] WB_ADR_I,
    input wire logic [3:0]        WB_SEL_I,
    input wire logic [31:0]       WB_DAT_I,
    input wire logic [31:0]       WB_DAT_O,
    input wire logic              WB_ACK_O,
    // Link and interrupt
    input wire logic              SERIAL_CLOCK_PIN,
    input wire logic              IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    logic req;
    assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;

    chk_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    chk_ack_after_req: assert property (req |=> WB_ACK_O)
        else $error("request not acked next cycle");
    chk_ack_needs_req: assert property (WB_ACK_O |-> $past(req))
        else $error("ack without request");
    chk_data_on_read: assert property ($changed(WB_DAT_O) |->
        $past(req && !WB_WE_I)) else $error("read data moved without read");
    chk_unmapped_zero: assert property (req && !WB_WE_I &&
        WB_ADR_I > OFS_DIVIDE |=> WB_DAT_O == 32'h0)
        else $error("unmapped read not zero");
    chk_irq_drop_write: assert property ($fell(IRQ) |->
        $past(req && WB_WE_I, 2)) else $error("irq fell without write");
    chk_mask_kills_irq: assert property (req && WB_WE_I &&
        WB_SEL_I[0] && WB_ADR_I == OFS_IRQ_MASK && WB_DAT_I[1:0] == 2'h0
        |-> ##2 !IRQ) else $error("irq high with mask zero");
    chk_sck_half_min: assert property ($changed(SERIAL_CLOCK_PIN)
        |=> $stable(SERIAL_CLOCK_PIN)) else $error("serial clock too fast");
endmodule : spi_rx_asserts

bind spi_master_receive_channel spi_rx_asserts #(.ADDR_W(ADDR_W))
    spi_rx_asserts_inst (.CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN), .IRQ(IRQ));

// ### test/spi_slave_model.sv
// Serial slave model shifting a bit stream onto the data line
`timescale 1ns/1ps
module spi_slave_model (
    // Link
    input  wire logic        sck,
    output logic             sdi,
    // Setup
    input  wire logic        load,
    input  wire logic [15:0] stream,
    input  wire logic        phase,
    input  wire logic        pol
);
    logic [15:0] sh;
    logic        first;
    logic        prev;
    assign sdi = sh[15];
    // Data moves on the sampling edge, just after the master takes the bit, so it is
    // settled a full bit period before the master looks at it
    always @(sck, load) begin
        if (load) begin
            sh    = stream;
            first = 1'b1;
        end else if (sck !== prev) begin
            if (sck === pol && !phase) begin
                if (first)
                    first = 1'b0;
                else
                    sh = {sh[14:0], ~sh[0]};
            end else if (sck !== pol && phase) begin
                sh = {sh[14:0], ~sh[0]};
            end
        end
        prev = sck;
    end
endmodule : spi_slave_model
